// File: tcs_defs.svh
// Offsets, field positions and reset values for the block
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH
`define TCS_ADDR_W        4
`define TCS_OFF_CTRL      4'h0
`define TCS_OFF_MASK      4'h1
`define TCS_BIT_TSD_EVT   0
`define TCS_BIT_TXTO_EVT  1
`define TCS_BIT_TSD_LIVE  2
`define TCS_BIT_TXTO_LIVE 3
`define TCS_BIT_FS_DIS    5
`define TCS_BIT_ACTIVE    7
`define TCS_BIT_MODE_LO   8
`define TCS_BIT_MODE_HI   9
`define TCS_BIT_WAKE_BYP  10
`define TCS_RESET_CTRL    16'h0000
`define TCS_RESET_MASK    16'h0000
`define TCS_UNMAPPED_RD   16'h0000
`endif

// File: tcs_pkg.sv
// Types shared by the transceiver control and status block
package tcs_pkg;
    typedef enum logic [1:0] {
        TCS_MODE_OFFLINE,
        TCS_MODE_RX_ONLY,
        TCS_MODE_ACTIVE_A,
        TCS_MODE_ACTIVE_B
    } tcs_mode_type;

    // Transceiver enables handed to the analogue front end
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic uv_react;
    } tcs_xcvr_ctl_type;

    // Live conditions reported by the transceiver
    typedef struct packed {
        logic thermal_shutdown;
        logic tx_dominant_timeout;
    } tcs_cond_type;
endpackage : tcs_pkg

// File: tcs_event_latch.sv
// One sticky event flag with write-one-to-clear
`timescale 1ns/1ps
module tcs_event_latch (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic enable_i,
    input  wire logic event_i,
    input  wire logic clear_i,
    output logic      flag_o
);
    // Set wins over clear so a recurring event is never lost
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (enable_i) begin
            if (event_i) begin
                flag_o <= 1'b1; // RQ12
            end else if (clear_i) begin
                flag_o <= 1'b0;
            end
        end
    end
endmodule : tcs_event_latch

// File: tcs_ctrl_status.sv
// Transceiver control and status register bank
//
// Behaviour
// [RQ1] Bit 0 latches thermal shutdown, cleared by writing one or reset.
// [RQ2] Bit 1 latches transmit dominant timeout, cleared by writing one.
// [RQ3] Bit 2 shows live thermal shutdown condition, not latched.
// [RQ4] Bit 3 shows live transmit dominant timeout condition.
// [RQ5] Bit 5 zero forces offline on reset or limp-home; one keeps state.
// [RQ6] Bit 7 reads one while in receive-only or active mode.
// [RQ7] Bits 8-9 select mode: 00 offline, 01 receive only; reset 00.
// [RQ8] Codes 10 and 11 enable transmit and receive, reacting on undervolt.
// [RQ9] Bit 10 one bypasses the receive hold after a bus wake-up.
// [RQ10] Mask register bits inhibit each latched event's interrupt.
// [RQ11] Zero bits read zero; writes to status and reserved bits ignored.
// [RQ12] Setting a latched event wins over a simultaneous clear.
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_ctrl_status
    import tcs_pkg::*;
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   clk_en_i,
    input  wire logic [`TCS_ADDR_W-1:0] addr_i,
    input  wire logic [15:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    input  wire tcs_cond_type           cond_i,
    input  wire logic                   reset_output_n_i,
    input  wire logic                   limp_home_output_i,
    input  wire logic                   ldo_undervoltage_i,
    output logic [15:0]                 rdata_o,
    output tcs_xcvr_ctl_type            xcvr_ctl_o,
    output logic                        wake_rx_hold_bypass_o,
    output logic                        uv_offline_o,
    output logic                        event_irq_o
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    logic         thermal_shutdown_event;
    logic         tx_dominant_timeout_event;
    logic         thermal_shutdown_live;
    logic         tx_dominant_timeout_live;
    logic         failsafe_offline_disable;
    logic         wake_rx_hold_bypass;
    logic         thermal_event_mask;
    logic         tx_timeout_event_mask;
    tcs_mode_type mode_reg;
    logic         failsafe_trip;
    logic         wr_ctrl;
    logic         wr_mask;
    logic         active_mode;
    // Decoded enables held in a net; a field select on a call is not legal
    tcs_xcvr_ctl_type mode_ctl;

    // Mode code to transceiver enables, used by output and readback
    function automatic tcs_xcvr_ctl_type mode_decode(tcs_mode_type m);
        tcs_xcvr_ctl_type c;
        c = '0;
        case (m)
            TCS_MODE_OFFLINE: c = '0;                      // RQ7
            TCS_MODE_RX_ONLY: c.rx_enable = 1'b1;          // RQ7
            default: c = '{1'b1, 1'b1, 1'b1};              // RQ8
        endcase
        return c;
    endfunction : mode_decode

    // Address decode, write side
    always_comb begin
        wr_ctrl = 1'b0;
        wr_mask = 1'b0;
        if (wr_i && addr_i == `TCS_OFF_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (wr_i && addr_i == `TCS_OFF_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // Reset or limp-home pulls the link offline unless disabled
    assign failsafe_trip = (!reset_output_n_i || limp_home_output_i)
                           && !failsafe_offline_disable;   // RQ5
    assign mode_ctl    = mode_decode(mode_reg);
    assign active_mode = mode_ctl.rx_enable;               // RQ6

    // ****************************************************************
    // Sticky event flags
    // ****************************************************************
    tcs_event_latch u_tsd_latch (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .enable_i (clk_en_i),
        .event_i  (cond_i.thermal_shutdown),
        .clear_i  (wr_ctrl && wdata_i[`TCS_BIT_TSD_EVT]),   // RQ1
        .flag_o   (thermal_shutdown_event)
    );
    tcs_event_latch u_txto_latch (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .enable_i (clk_en_i),
        .event_i  (cond_i.tx_dominant_timeout),
        .clear_i  (wr_ctrl && wdata_i[`TCS_BIT_TXTO_EVT]),  // RQ2
        .flag_o   (tx_dominant_timeout_event)
    );

    // Live conditions registered once, shown without latching
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thermal_shutdown_live    <= 1'b0;
            tx_dominant_timeout_live <= 1'b0;
        end else if (clk_en_i) begin
            thermal_shutdown_live    <= cond_i.thermal_shutdown;    // RQ3
            tx_dominant_timeout_live <= cond_i.tx_dominant_timeout; // RQ4
        end
    end

    // ****************************************************************
    // Writable control fields
    // ****************************************************************
    // Fail-safe trip wins over a mode write in the same cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg                 <= TCS_MODE_OFFLINE;
            failsafe_offline_disable <= 1'b0;
            wake_rx_hold_bypass      <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_ctrl) begin
                failsafe_offline_disable <= wdata_i[`TCS_BIT_FS_DIS];
                wake_rx_hold_bypass      <= wdata_i[`TCS_BIT_WAKE_BYP]; // RQ9
            end
            if (failsafe_trip) begin
                mode_reg <= TCS_MODE_OFFLINE;                       // RQ5
            end else if (wr_ctrl) begin
                mode_reg <= tcs_mode_type'(
                    wdata_i[`TCS_BIT_MODE_HI:`TCS_BIT_MODE_LO]);    // RQ7
            end
        end
    end

    // Interrupt mask register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thermal_event_mask    <= 1'b0;
            tx_timeout_event_mask <= 1'b0;
        end else if (clk_en_i && wr_mask) begin
            thermal_event_mask    <= wdata_i[`TCS_BIT_TSD_EVT];     // RQ10
            tx_timeout_event_mask <= wdata_i[`TCS_BIT_TXTO_EVT];    // RQ10
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Enables follow the mode; undervoltage drops only active modes
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xcvr_ctl_o            <= '0;
            wake_rx_hold_bypass_o <= 1'b0;
            uv_offline_o          <= 1'b0;
            event_irq_o           <= 1'b0;
        end else if (clk_en_i) begin
            xcvr_ctl_o            <= mode_ctl;
            wake_rx_hold_bypass_o <= wake_rx_hold_bypass;           // RQ9
            uv_offline_o <= mode_ctl.uv_react
                            && ldo_undervoltage_i;                  // RQ8
            event_irq_o <=
                (thermal_shutdown_event && !thermal_event_mask) ||
                (tx_dominant_timeout_event && !tx_timeout_event_mask); // RQ10
        end
    end

    // Read data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= `TCS_UNMAPPED_RD;
        end else if (clk_en_i) begin
            rdata_o <= `TCS_UNMAPPED_RD;                            // RQ11
            if (rd_i && addr_i == `TCS_OFF_CTRL) begin
                rdata_o[`TCS_BIT_TSD_EVT]   <= thermal_shutdown_event;
                rdata_o[`TCS_BIT_TXTO_EVT]  <= tx_dominant_timeout_event;
                rdata_o[`TCS_BIT_TSD_LIVE]  <= thermal_shutdown_live;
                rdata_o[`TCS_BIT_TXTO_LIVE] <= tx_dominant_timeout_live;
                rdata_o[`TCS_BIT_FS_DIS]    <= failsafe_offline_disable;
                rdata_o[`TCS_BIT_ACTIVE]    <= active_mode;         // RQ6
                rdata_o[`TCS_BIT_MODE_HI:`TCS_BIT_MODE_LO] <= mode_reg;
                rdata_o[`TCS_BIT_WAKE_BYP]  <= wake_rx_hold_bypass;
            end else if (rd_i && addr_i == `TCS_OFF_MASK) begin
                rdata_o[`TCS_BIT_TSD_EVT]   <= thermal_event_mask;
                rdata_o[`TCS_BIT_TXTO_EVT]  <= tx_timeout_event_mask;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    tsd_event_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && cond_i.thermal_shutdown |=> thermal_shutdown_event)
        else $error("thermal event not latched"); // RQ1
    txto_event_set_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        clk_en_i && cond_i.tx_dominant_timeout && wr_ctrl
        |=> tx_dominant_timeout_event)
        else $error("timeout event lost on clear"); // RQ12
    tsd_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && wr_ctrl && wdata_i[0] && !cond_i.thermal_shutdown
        |=> !thermal_shutdown_event)
        else $error("thermal event not cleared"); // RQ1
    live_tsd_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i ##1 1'b1 |-> thermal_shutdown_live ==
        $past(cond_i.thermal_shutdown))
        else $error("live thermal status wrong"); // RQ3
    live_txto_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i ##1 1'b1 |-> tx_dominant_timeout_live ==
        $past(cond_i.tx_dominant_timeout))
        else $error("live timeout status wrong"); // RQ4
    failsafe_off_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        clk_en_i && failsafe_trip ##1 clk_en_i
        |=> !xcvr_ctl_o.tx_enable && !xcvr_ctl_o.rx_enable)
        else $error("fail-safe did not go offline"); // RQ5
    active_read_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        clk_en_i && rd_i && addr_i == `TCS_OFF_CTRL
        |=> rdata_o[7] == ($past(mode_reg) != TCS_MODE_OFFLINE))
        else $error("active mode bit wrong"); // RQ6
    irq_mask_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        clk_en_i && thermal_event_mask && tx_timeout_event_mask
        |=> !event_irq_o)
        else $error("masked event raised interrupt"); // RQ10
    reserved_zero_a: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        rdata_o[15:11] == 5'h00 && !rdata_o[6] && !rdata_o[4])
        else $error("reserved bit read nonzero"); // RQ11
endmodule : tcs_ctrl_status

// File: tcs_bus_model.sv
// Model of the transceiver and supervisor that face the register bank
`timescale 1ns/1ps
module tcs_bus_model
    import tcs_pkg::*;
(
    input  wire logic    clock_i,
    input  wire logic    hot_i,
    input  wire logic    stuck_i,
    input  wire logic    trip_i,
    input  wire logic    limp_i,
    input  wire logic    uv_i,
    output tcs_cond_type cond_o,
    output logic         reset_output_n_o,
    output logic         limp_home_output_o,
    output logic         ldo_undervoltage_o
);
    // Sensor levels lag the command by one edge, as slow analogue would
    always_ff @(posedge clock_i) begin
        cond_o.thermal_shutdown    <= hot_i;
        cond_o.tx_dominant_timeout <= stuck_i;
        reset_output_n_o           <= ~trip_i; // Active low supervisor
        limp_home_output_o         <= limp_i;
        ldo_undervoltage_o         <= uv_i;
    end
endmodule : tcs_bus_model

// File: tb_tcs_ctrl_status.sv
// Self-checking bench for the transceiver control and status bank
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tb_tcs_ctrl_status
    import tcs_pkg::*;
;
    logic             clock_i = 1'b0;
    logic             rst_n_i = 1'b0;
    logic             clk_en  = 1'b1;
    logic [3:0]       addr_i  = 4'h0;
    logic [15:0]      wdata_i = 16'h0000;
    logic             wr_i    = 1'b0;
    logic             rd_i    = 1'b0;
    logic             hot     = 1'b0;
    logic             stuck   = 1'b0;
    logic             trip    = 1'b0;
    logic             limp    = 1'b0;
    logic             uv      = 1'b0;
    tcs_cond_type     cond;
    logic             rst_out_n;
    logic             limp_out;
    logic             uv_out;
    logic [15:0]      rdata_o;
    tcs_xcvr_ctl_type xcvr_ctl_o;
    logic             byp_o;
    logic             uv_off_o;
    logic             irq_o;
    int               miscompares = 0;
    int               n_tests     = 0;
    int               cycles      = 0;
    logic [15:0]      row_w [4];
    logic [15:0]      row_r [4];
    logic [2:0]       row_x [4];

    always #4 clock_i = ~clock_i;

    tcs_bus_model u_tcs_bus_model (.clock_i(clock_i), .hot_i(hot),
        .stuck_i(stuck), .trip_i(trip), .limp_i(limp), .uv_i(uv),
        .cond_o(cond), .reset_output_n_o(rst_out_n),
        .limp_home_output_o(limp_out), .ldo_undervoltage_o(uv_out));

    tcs_ctrl_status u_tcs_ctrl_status (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .clk_en_i(clk_en), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .cond_i(cond),
        .reset_output_n_i(rst_out_n), .limp_home_output_i(limp_out),
        .ldo_undervoltage_i(uv_out), .rdata_o(rdata_o),
        .xcvr_ctl_o(xcvr_ctl_o), .wake_rx_hold_bypass_o(byp_o),
        .uv_offline_o(uv_off_o), .event_irq_o(irq_o));

    // Hang guard; the whole run needs well under 400 cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One-cycle strobes, changed only just after a rising edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : wait_cyc

    initial begin
        // Write data, read-back, then enables {tx, rx, undervolt react}
        row_w = '{16'hF800, 16'h0120, 16'h0200, 16'h07DC};
        row_r = '{16'h0000, 16'h01A0, 16'h0280, 16'h0780};
        row_x = '{3'h0, 3'h2, 3'h7, 3'h7};
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        #1 chk({13'h0, xcvr_ctl_o, byp_o, uv_off_o, irq_o}, 16'h0000);
        rd(`TCS_OFF_CTRL, `TCS_RESET_CTRL);
        rd(`TCS_OFF_MASK, `TCS_RESET_MASK);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(`TCS_OFF_CTRL, row_w[i]);
            rd(`TCS_OFF_CTRL, row_r[i]);
            chk({13'h0, xcvr_ctl_o}, {13'h0, row_x[i]});
            chk({15'h0, byp_o}, {15'h0, row_r[i][10]});
        end
        $display("mode table done");
        wr(`TCS_OFF_CTRL, 16'h0000);
        wr(4'h5, 16'hFFFF);
        rd(4'h5, `TCS_UNMAPPED_RD);
        rd(`TCS_OFF_CTRL, 16'h0000);
        $display("unmapped done");
        // Both events live, then a clear while they persist
        hot   <= 1'b1;
        stuck <= 1'b1;
        wait_cyc(4);
        chk({15'h0, irq_o}, 16'h0001);
        rd(`TCS_OFF_CTRL, 16'h000F);
        wr(`TCS_OFF_CTRL, 16'h0003);
        rd(`TCS_OFF_CTRL, 16'h000F);
        hot   <= 1'b0;
        stuck <= 1'b0;
        wait_cyc(3);
        rd(`TCS_OFF_CTRL, 16'h0003);
        wr(`TCS_OFF_MASK, 16'hFFFF);
        rd(`TCS_OFF_MASK, 16'h0003);
        wait_cyc(2);
        chk({15'h0, irq_o}, 16'h0000);
        wr(`TCS_OFF_CTRL, 16'h0001);
        rd(`TCS_OFF_CTRL, 16'h0002);
        wr(`TCS_OFF_CTRL, 16'h0002);
        rd(`TCS_OFF_CTRL, 16'h0000);
        $display("events done");
        // Limp-home trip with failsafe armed, then a supervisor reset trip with it disabled
        wr(`TCS_OFF_CTRL, 16'h0300);
        limp <= 1'b1;
        wait_cyc(4);
        rd(`TCS_OFF_CTRL, 16'h0000);
        chk({13'h0, xcvr_ctl_o}, 16'h0000);
        limp <= 1'b0;
        wr(`TCS_OFF_CTRL, 16'h0320);
        trip <= 1'b1;
        uv   <= 1'b1;
        wait_cyc(4);
        rd(`TCS_OFF_CTRL, 16'h03A0);
        chk({15'h0, uv_off_o}, 16'h0001);
        trip <= 1'b0;
        wr(`TCS_OFF_CTRL, 16'h0100);
        wait_cyc(3);
        chk({15'h0, uv_off_o}, 16'h0000);
        $display("failsafe done");
        // Enable low freezes all state, so a write then is lost
        clk_en <= 1'b0;
        wr(`TCS_OFF_CTRL, 16'h0200);
        clk_en <= 1'b1;
        rd(`TCS_OFF_CTRL, 16'h0180);
        $display("clock enable done");
        // Reset in mid-run returns every field to its reset value
        rst_n_i <= 1'b0;
        wait_cyc(2);
        rst_n_i <= 1'b1;
        rd(`TCS_OFF_CTRL, `TCS_RESET_CTRL);
        chk({13'h0, xcvr_ctl_o, byp_o, uv_off_o, irq_o}, 16'h0000);
        rd(`TCS_OFF_MASK, `TCS_RESET_MASK);
        $display("mid-run reset done");
        stop_test();
    end
endmodule : tb_tcs_ctrl_status
